//--- sbw_consts.svh
// Offsets, field positions, reset values, codes and timing counts of the
// self-test, bus-level and watchdog register group.
// Assumes a 250 MHz core clock and 32-bit AHB-Lite register access.
`ifndef SBW_CONSTS_SVH
`define SBW_CONSTS_SVH

// Register indexes; byte address is four times the index
`define SBW_IDX_SELF_TEST 8'h14
`define SBW_IDX_BUS_LEVEL 8'h15
`define SBW_IDX_WD_CTRL 8'h16
`define SBW_ADDR_IDX_MSB 9
`define SBW_ADDR_IDX_LSB 2

// Reset values
`define SBW_RST_SELF_TEST 8'h00
`define SBW_RST_BUS_LEVEL 8'h01
`define SBW_RST_WD_CTRL 8'hfe

// Field positions
`define SBW_OSC_SEL_MSB 2
`define SBW_OSC_SEL_LSB 1
`define SBW_SELF_TEST_ON_BIT 0
`define SBW_WD_TIMEOUT_MSB 7
`define SBW_WD_TIMEOUT_LSB 1
`define SBW_WD_DISABLE_BIT 0

// Frame oscillator select codes
`define SBW_OSC_CODE_PIX 2'h0
`define SBW_OSC_CODE_50 2'h1
`define SBW_OSC_CODE_100 2'h2
`define SBW_OSC_CODE_25 2'h3

// Bus-level control codes and states
`define SBW_LEVEL_SET_CODE 8'hb5
`define SBW_LEVEL_CLR_CODE 8'hb6
`define SBW_LEVEL_3V3 1'b1
`define SBW_LEVEL_1V8 1'b0

// Bus signalling
`define SBW_HTRANS_ACTIVE_BIT 1
`define SBW_HRESP_OKAY 1'b0

// Watchdog step of 2 ms at the core clock rate
`define SBW_CLK_MHZ 250
`define SBW_WD_STEP_US 2000
`define SBW_WD_STEP_CYCLES (`SBW_WD_STEP_US * `SBW_CLK_MHZ)

`endif

//--- sbw_pkg.sv
// Types shared by the register group and its watchdog timer.
// Assumes sbw_consts.svh supplies the numeric constants.
package sbw_pkg;

  // Clock source handed to the frame builder, one-hot
  typedef enum logic [3:0] {
    SBW_SRC_PIXEL = 4'h1,
    SBW_SRC_OSC50 = 4'h2,
    SBW_SRC_OSC100 = 4'h4,
    SBW_SRC_OSC25 = 4'h8
  } sbw_clk_src_type;

  // Watchdog state, one-hot
  typedef enum logic [1:0] {
    SBW_WD_IDLE = 2'h1,
    SBW_WD_BUSY = 2'h2
  } sbw_wd_state_type;

  // Clock selection result
  typedef struct packed {
    logic self_test;
    sbw_clk_src_type src;
  } sbw_clk_sel_type;

  // Captured bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] idx;
  } sbw_bus_req_type;

  // Byte write coming from fuse programming
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sbw_code_wr_type;

endpackage

//--- sbw_watchdog.sv
// Control-channel watchdog: counts 2 ms steps while a transaction is open
// and aborts it on timeout. Assumes start and done are one-cycle pulses.
`timescale 1ns/1ps
`include "sbw_consts.svh"
module sbw_watchdog #(
  parameter int unsigned STEP_CYCLES = `SBW_WD_STEP_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic txn_start,
  input wire logic txn_done,
  input wire logic wd_disable,
  input wire logic [6:0] wd_timeout,
  output logic txn_abort,
  output logic wd_busy
);
  import sbw_pkg::*;

  sbw_wd_state_type state_ff;
  logic [31:0] cyc_cnt_ff;
  logic [6:0] step_cnt_ff;
  logic abort_ff;
  logic step_end;
  logic expire;

  // Step boundary and expiry while enabled
  assign step_end = (cyc_cnt_ff == 32'(STEP_CYCLES - 1));
  assign expire = (state_ff == SBW_WD_BUSY) && !wd_disable && !txn_done && (step_cnt_ff >= wd_timeout);

  // Transaction state; expiry returns to idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= SBW_WD_IDLE;
    end else begin
      case (state_ff)
        SBW_WD_IDLE: begin
          if (txn_start) begin
            state_ff <= SBW_WD_BUSY;
          end
        end
        SBW_WD_BUSY: begin
          if (txn_done || expire) begin
            state_ff <= SBW_WD_IDLE;
          end
        end
        default: state_ff <= SBW_WD_IDLE;
      endcase
    end
  end

  // Step counters, cleared outside a transaction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt_ff <= 32'h0;
      step_cnt_ff <= 7'h0;
    end else if (state_ff != SBW_WD_BUSY) begin
      cyc_cnt_ff <= 32'h0;
      step_cnt_ff <= 7'h0;
    end else if (step_end) begin
      cyc_cnt_ff <= 32'h0;
      if (step_cnt_ff != 7'h7f) begin
        step_cnt_ff <= step_cnt_ff + 7'h1;
      end
    end else begin
      cyc_cnt_ff <= cyc_cnt_ff + 32'h1;
    end
  end

  // Abort pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abort_ff <= 1'b0;
    end else begin
      abort_ff <= expire;
    end
  end

  assign txn_abort = abort_ff;
  assign wd_busy = (state_ff == SBW_WD_BUSY);

  a_wd_expire_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    expire |=> txn_abort && state_ff == SBW_WD_IDLE) else $error("watchdog expiry did not abort");
  a_wd_abort_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    txn_abort |-> $past(state_ff) == SBW_WD_BUSY && !$past(wd_disable)
      && $past(step_cnt_ff) >= $past(wd_timeout)) else $error("abort without a timeout");
  a_wd_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    wd_disable |=> !txn_abort) else $error("disabled watchdog aborted");
  a_wd_step_count: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == SBW_WD_BUSY && step_end && !txn_done && !expire && step_cnt_ff != 7'h7f
      |=> step_cnt_ff == $past(step_cnt_ff) + 7'h1) else $error("step count missed");
  a_wd_idle_after: assert property (@(posedge hclk) disable iff (!hresetn)
    txn_abort |-> !wd_busy ##1 (wd_busy == $past(txn_start))) else $error("channel not idle after abort");
  c_wd_abort: cover property (@(posedge hclk) disable iff (!hresetn) txn_abort);
endmodule

//--- sbw_regs.sv
// Self-test clock, bus-level select and watchdog control registers with an
// AHB-Lite slave port. Assumes inputs synchronous to hclk and a single slave.
//
// Function
// - Free-run frame oscillator chosen by select field
// - Self-test clock source chosen by select field
// - Self-test enable bit read-only, shows status
// - Bus level loaded from strap after power-up
// - Digital reset returns bus level to 3.3V
// - Bus level read: 0 is 1.8V, 1 3.3V
// - Only codes 0xb5/0xb6 set or clear level
// - Enabled watchdog aborts overdue channel transaction
// - Timeout field bits 7:1, 2 ms steps
// - Watchdog disable bit zero, default enabled
`timescale 1ns/1ps
`include "sbw_consts.svh"
module sbw_regs #(
  parameter int unsigned WD_STEP_CYCLES = `SBW_WD_STEP_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pclk_present,
  input wire logic free_run_en,
  input wire logic self_test_active,
  input wire logic bus_level_strap_pin,
  input wire logic digital_reset,
  input wire sbw_pkg::sbw_code_wr_type fuse_store_wr,
  input wire logic txn_start,
  input wire logic txn_done,
  output sbw_pkg::sbw_clk_sel_type clk_sel,
  output logic bus_level_ctrl,
  output logic txn_abort,
  output logic wd_busy
);
  import sbw_pkg::*;

  sbw_bus_req_type req_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic rd_pending_ff;
  logic [7:0] rd_idx_ff;
  logic [1:0] frame_osc_select_ff;
  logic bus_level_ctrl_ff;
  logic strap_pending_ff;
  logic [6:0] wd_timeout_ff;
  logic wd_disable_ff;
  sbw_clk_sel_type clk_sel_ff;
  sbw_clk_sel_type nxt_clk_sel;
  logic addr_ok;
  logic wr_go;
  logic [7:0] wr_byte;
  logic lvl_set;
  logic lvl_clr;
  logic [7:0] rd_value;

  // Decode of the select field; functional mode folds the pixel code onto 50 MHz
  function automatic sbw_clk_src_type osc_decode(input logic [1:0] code, input logic self_test);
    sbw_clk_src_type src;
    src = SBW_SRC_OSC50;
    case (code)
      `SBW_OSC_CODE_PIX: src = self_test ? SBW_SRC_PIXEL : SBW_SRC_OSC50;
      `SBW_OSC_CODE_50: src = SBW_SRC_OSC50;
      `SBW_OSC_CODE_100: src = SBW_SRC_OSC100;
      `SBW_OSC_CODE_25: src = SBW_SRC_OSC25;
      default: src = SBW_SRC_OSC50;
    endcase
    return src;
  endfunction

  // Register view for a given index; unmapped reads as zero
  function automatic logic [7:0] reg_view(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `SBW_IDX_SELF_TEST: begin
        v[`SBW_OSC_SEL_MSB:`SBW_OSC_SEL_LSB] = frame_osc_select_ff;
        v[`SBW_SELF_TEST_ON_BIT] = self_test_active;
      end
      `SBW_IDX_BUS_LEVEL: v[0] = bus_level_ctrl_ff;
      `SBW_IDX_WD_CTRL: begin
        v[`SBW_WD_TIMEOUT_MSB:`SBW_WD_TIMEOUT_LSB] = wd_timeout_ff;
        v[`SBW_WD_DISABLE_BIT] = wd_disable_ff;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Address-phase acceptance and data-phase write strobe
  assign addr_ok = hsel && hready && htrans[`SBW_HTRANS_ACTIVE_BIT];
  assign wr_go = req_ff.valid && req_ff.write;
  assign wr_byte = hwdata[7:0];
  assign rd_value = reg_view(rd_idx_ff);

  // Capture address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= '0;
    end else if (hready) begin
      req_ff.valid <= addr_ok;
      req_ff.write <= hwrite;
      req_ff.idx <= haddr[`SBW_ADDR_IDX_MSB:`SBW_ADDR_IDX_LSB];
    end
  end

  // Reads insert one wait state so data comes from a flop after earlier writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pending_ff <= 1'b0;
      rd_idx_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0;
    end else begin
      rd_pending_ff <= addr_ok && !hwrite;
      if (addr_ok && !hwrite) begin
        rd_idx_ff <= haddr[`SBW_ADDR_IDX_MSB:`SBW_ADDR_IDX_LSB];
        hreadyout_ff <= 1'b0;
      end else begin
        hreadyout_ff <= 1'b1;
      end
      if (rd_pending_ff) begin
        hrdata_ff <= {24'h0, rd_value};
      end
    end
  end

  // Self-test clock control field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_osc_select_ff <= 2'(`SBW_RST_SELF_TEST >> `SBW_OSC_SEL_LSB);
    end else if (wr_go && req_ff.idx == `SBW_IDX_SELF_TEST) begin
      frame_osc_select_ff <= wr_byte[`SBW_OSC_SEL_MSB:`SBW_OSC_SEL_LSB];
    end
  end

  // Watchdog control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_timeout_ff <= 7'(`SBW_RST_WD_CTRL >> `SBW_WD_TIMEOUT_LSB);
      wd_disable_ff <= 1'(`SBW_RST_WD_CTRL & 8'h01);
    end else if (wr_go && req_ff.idx == `SBW_IDX_WD_CTRL) begin
      wd_timeout_ff <= wr_byte[`SBW_WD_TIMEOUT_MSB:`SBW_WD_TIMEOUT_LSB];
      wd_disable_ff <= wr_byte[`SBW_WD_DISABLE_BIT];
    end
  end

  // Level codes from the bus or from fuse programming
  assign lvl_set = (wr_go && req_ff.idx == `SBW_IDX_BUS_LEVEL && wr_byte == `SBW_LEVEL_SET_CODE)
    || (fuse_store_wr.valid && fuse_store_wr.data == `SBW_LEVEL_SET_CODE);
  assign lvl_clr = (wr_go && req_ff.idx == `SBW_IDX_BUS_LEVEL && wr_byte == `SBW_LEVEL_CLR_CODE)
    || (fuse_store_wr.valid && fuse_store_wr.data == `SBW_LEVEL_CLR_CODE);

  // Bus-level control: reset, then strap, then codes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_level_ctrl_ff <= 1'(`SBW_RST_BUS_LEVEL & 8'h01);
      strap_pending_ff <= 1'b1;
    end else begin
      strap_pending_ff <= 1'b0;
      if (digital_reset) begin
        bus_level_ctrl_ff <= `SBW_LEVEL_3V3;
      end else if (strap_pending_ff) begin
        bus_level_ctrl_ff <= bus_level_strap_pin ? `SBW_LEVEL_1V8 : `SBW_LEVEL_3V3;
      end else if (lvl_set) begin
        bus_level_ctrl_ff <= 1'b1;
      end else if (lvl_clr) begin
        bus_level_ctrl_ff <= 1'b0;
      end
    end
  end

  // Clock source selection
  always_comb begin
    nxt_clk_sel.self_test = self_test_active;
    nxt_clk_sel.src = SBW_SRC_PIXEL;
    if (self_test_active) begin
      nxt_clk_sel.src = osc_decode(frame_osc_select_ff, 1'b1);
    end else if (!pclk_present && free_run_en) begin
      nxt_clk_sel.src = osc_decode(frame_osc_select_ff, 1'b0);
    end
  end

  // Registered clock selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sel_ff <= {1'b0, SBW_SRC_PIXEL};
    end else begin
      clk_sel_ff <= nxt_clk_sel;
    end
  end

  // Control-channel watchdog
  sbw_watchdog #(
    .STEP_CYCLES(WD_STEP_CYCLES)
  ) u_watchdog (
    .hclk(hclk),
    .hresetn(hresetn),
    .txn_start(txn_start),
    .txn_done(txn_done),
    .wd_disable(wd_disable_ff),
    .wd_timeout(wd_timeout_ff),
    .txn_abort(txn_abort),
    .wd_busy(wd_busy)
  );

  // Outputs from flops; hresp is tied to OKAY
  assign hreadyout = hreadyout_ff;
  assign hresp = `SBW_HRESP_OKAY;
  assign hrdata = hrdata_ff;
  assign clk_sel = clk_sel_ff;
  assign bus_level_ctrl = bus_level_ctrl_ff;

  a_osc_functional: assert property (@(posedge hclk) disable iff (!hresetn)
    !self_test_active && !pclk_present && free_run_en
      |=> clk_sel.src == osc_decode($past(frame_osc_select_ff), 1'b0)) else $error("wrong free-run osc");
  a_osc_self_test: assert property (@(posedge hclk) disable iff (!hresetn)
    self_test_active && frame_osc_select_ff == `SBW_OSC_CODE_PIX
      |=> clk_sel.src == SBW_SRC_PIXEL && clk_sel.self_test) else $error("self-test not on pixel clock");
  a_self_test_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pending_ff && rd_idx_ff == `SBW_IDX_SELF_TEST
      |=> hreadyout && hrdata[0] == $past(self_test_active)) else $error("self-test bit read wrong");
  a_strap_load: assert property (@(posedge hclk) disable iff (!hresetn)
    strap_pending_ff && !digital_reset |=> bus_level_ctrl == !$past(bus_level_strap_pin)) else $error("strap not loaded");
  a_level_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    digital_reset |=> bus_level_ctrl == `SBW_LEVEL_3V3) else $error("level not reset to 3.3V");
  a_level_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pending_ff && rd_idx_ff == `SBW_IDX_BUS_LEVEL |=> hrdata == {31'h0, $past(bus_level_ctrl_ff)}) else $error("level read wrong");
  a_level_codes: assert property (@(posedge hclk) disable iff (!hresetn)
    !strap_pending_ff && !digital_reset && !lvl_set && !lvl_clr |=> $stable(bus_level_ctrl)) else $error("level moved without code");
  a_level_set_code: assert property (@(posedge hclk) disable iff (!hresetn)
    !strap_pending_ff && !digital_reset && lvl_set |=> bus_level_ctrl) else $error("set code ignored");
  a_read_wait_one: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  c_read_self_test: cover property (@(posedge hclk) disable iff (!hresetn) rd_pending_ff && rd_idx_ff == `SBW_IDX_SELF_TEST);
  c_level_clear: cover property (@(posedge hclk) disable iff (!hresetn) lvl_clr && !digital_reset);
  c_self_test_100: cover property (@(posedge hclk) disable iff (!hresetn) clk_sel.self_test && clk_sel.src == SBW_SRC_OSC100);
endmodule

//--- tb.sv
// Self-checking bench for the self-test clock, bus-level and watchdog registers.
// Assumes a single AHB-Lite slave with hready fed back from hreadyout.
`timescale 1ns/1ps
module tb;
  import sbw_pkg::*;
  localparam int unsigned STEP = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout, hresp, bus_level_ctrl, txn_abort, wd_busy;
  logic [31:0] hrdata;
  logic pclk_present = 1'b0;
  logic free_run_en = 1'b0;
  logic self_test_active = 1'b0;
  logic bus_level_strap_pin = 1'b1;
  logic digital_reset = 1'b0;
  sbw_code_wr_type fuse_store_wr = '0;
  logic txn_start = 1'b0;
  logic txn_done = 1'b0;
  sbw_clk_sel_type clk_sel;
  int fail_count = 0;
  int n_compared = 0;

  // Clock of 250 MHz
  always #2 hclk = ~hclk;
  assign hready = hreadyout;

  sbw_regs #(.WD_STEP_CYCLES(STEP)) u_sbw_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pclk_present(pclk_present), .free_run_en(free_run_en),
    .self_test_active(self_test_active), .bus_level_strap_pin(bus_level_strap_pin), .digital_reset(digital_reset),
    .fuse_store_wr(fuse_store_wr), .txn_start(txn_start), .txn_done(txn_done), .clk_sel(clk_sel),
    .bus_level_ctrl(bus_level_ctrl), .txn_abort(txn_abort), .wd_busy(wd_busy));

  // Counts, verdict and end of run
  task finish_test;
    $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compare one result against its expectation
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Hold until hready is seen high at a rising edge; bounded
  task wait_rdy(output logic [31:0] rd);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge hclk);
      ok = (hready === 1'b1);
      rd = hrdata;
      @(posedge hclk);
      n++;
      if (n > 50) begin
        fail_count++;
        finish_test();
      end
    end
  endtask

  // One single AHB transfer: address phase, then data phase
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd);
    logic [31:0] r;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(r);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(rd);
    chk(hresp, 1'b0, "bus response");
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, exp, "register read");
  endtask

  // Expected clock selection from mode inputs and field code
  function automatic logic [4:0] exp_sel(input logic st, input logic pp, input logic fr, input logic [1:0] c);
    logic [3:0] src;
    src = 4'h1;
    if (st) begin
      src = 4'h1 << c;
    end else if (!pp && fr) begin
      src = (c == 2'h0) ? 4'h2 : (4'h1 << c);
    end
    return {st, src};
  endfunction

  // Start a transaction and let the watchdog expire it
  task wd_abort(input int t);
    int n;
    wr(32'h58, {24'h0, t[6:0], 1'b0});
    txn_start <= 1'b1;
    @(posedge hclk);
    txn_start <= 1'b0;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (txn_abort !== 1'b1 && n < 300);
    chk(32'(n >= t * 4 - 1 && n <= t * 4 + 3), 32'h1, "abort time");
    chk(wd_busy, 1'b0, "busy after abort");
    @(posedge hclk);
  endtask

  // Bound on the whole run
  initial begin
    repeat (100000) @(posedge hclk);
    fail_count++;
    finish_test();
  end

  initial begin
    logic [7:0] b;
    logic [1:0] c;
    logic st, pp, fr;
    int t, n;
    void'($urandom(32'he9b8ae3d));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and strap load
    rd_chk(32'h50, 32'h0);
    rd_chk(32'h58, 32'hfe);
    rd_chk(32'h54, 32'h0);
    chk(bus_level_ctrl, 1'b0, "strap level");
    wr(32'h5c, 32'hb5);
    rd_chk(32'h5c, 32'h0);
    rd_chk(32'h54, 32'h0);
    // Only the two codes move the level control
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      if (b == 8'hb5 || b == 8'hb6) b = 8'h00;
      wr(32'h54, {24'h0, b});
      rd_chk(32'h54, 32'h0);
    end
    wr(32'h54, 32'hb5);
    rd_chk(32'h54, 32'h1);
    wr(32'h54, 32'hb6);
    rd_chk(32'h54, 32'h0);
    for (int i = 0; i < 2; i++) begin
      fuse_store_wr <= '{valid: 1'b1, data: (i == 0) ? 8'hb5 : 8'hb6};
      @(posedge hclk);
      fuse_store_wr <= '0;
      @(negedge hclk);
      chk(bus_level_ctrl, (i == 0) ? 1'b1 : 1'b0, "fuse code");
      @(posedge hclk);
    end
    digital_reset <= 1'b1;
    @(posedge hclk);
    digital_reset <= 1'b0;
    @(negedge hclk);
    chk(bus_level_ctrl, 1'b1, "digital reset");
    @(posedge hclk);
    rd_chk(32'h54, 32'h1);
    // Every field code in self-test, free-run and normal modes
    for (int k = 0; k < 12; k++) begin
      c = k[1:0];
      st = (k / 4 == 0);
      pp = (k / 4 == 2);
      fr = (k / 4 == 1) ? 1'b1 : 1'($urandom);
      self_test_active <= st;
      pclk_present <= pp;
      free_run_en <= fr;
      wr(32'h50, {29'h0, c, 1'b1});
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      chk(clk_sel, exp_sel(st, pp, fr, c), "clock select");
      @(posedge hclk);
      rd_chk(32'h50, {29'h0, c, st});
    end
    self_test_active <= 1'b0;
    // Watchdog expiry with random legal timeouts
    for (int i = 0; i < 3; i++) begin
      t = 1 + ($urandom % 5);
      wd_abort(t);
    end
    rd_chk(32'h58, {24'h0, t[6:0], 1'b0});
    // Completed transaction is never aborted
    txn_start <= 1'b1;
    @(posedge hclk);
    txn_start <= 1'b0;
    txn_done <= 1'b1;
    @(posedge hclk);
    txn_done <= 1'b0;
    n = 0;
    repeat (8 * t) begin
      @(negedge hclk);
      if (txn_abort === 1'b1) n++;
    end
    chk(n, 0, "abort after done");
    chk(wd_busy, 1'b0, "idle after done");
    // Disabled watchdog keeps the transaction open
    @(posedge hclk);
    wr(32'h58, 32'h3);
    txn_start <= 1'b1;
    @(posedge hclk);
    txn_start <= 1'b0;
    n = 0;
    repeat (40) begin
      @(negedge hclk);
      if (txn_abort === 1'b1) n++;
    end
    chk(n, 0, "abort while disabled");
    chk(wd_busy, 1'b1, "busy while disabled");
    @(posedge hclk);
    txn_done <= 1'b1;
    @(posedge hclk);
    txn_done <= 1'b0;
    // Re-enabled watchdog accepts a new transaction and expires it
    wd_abort(2);
    finish_test();
  end
endmodule
